// ---- hw/sbcp_params.svh ----
`ifndef SBCP_PARAMS_SVH
`define SBCP_PARAMS_SVH

// =========================================
// Widths
`define SBCP_AW         14
`define SBCP_RW         14
`define SBCP_DW         16
`define SBCP_MW         2
`define SBCP_CW         6
`define SBCP_TW         8
`define SBCP_KW         10
`define SBCP_NB         8

// =========================================
// Address fields
`define SBCP_A_AP       10
`define SBCP_A_BL       12

// =========================================
// Timing
`define SBCP_CLK_PS     4000
`define SBCP_TRP_PS     15000
`define SBCP_REFRESH_CYCLE_TIME_PS    160000
`define SBCP_TRP_CYC    ((`SBCP_TRP_PS + `SBCP_CLK_PS - 1) / `SBCP_CLK_PS)
`define SBCP_REFRESH_CYCLE_TIME_CYC   ((`SBCP_REFRESH_CYCLE_TIME_PS + `SBCP_CLK_PS - 1) / `SBCP_CLK_PS)
`define SBCP_ZQINIT_CYC 512
`define SBCP_ZQOPER_CYC 256
`define SBCP_SHORT_IMPEDANCE_CALIBRATION_CYC   64
`define SBCP_LAST_BL8   3'h7
`define SBCP_LAST_BC4   3'h3
`define SBCP_CODE_RST   6'h20

`endif

// ---- hw/sbcp_pkg.sv ----
`include "sbcp_params.svh"

package sbcp_pkg;

    // =========================================
    // Bundles
    typedef struct packed {
        logic                 cs_n;
        logic                 ras_n;
        logic                 cas_n;
        logic                 we_n;
        logic                 cke;
        logic [2:0]           ba;
        logic [`SBCP_AW-1:0]  addr;
    } sbcp_pins_type;

    typedef struct packed {
        logic                 valid;
        logic [`SBCP_MW-1:0]  mask;
        logic [`SBCP_DW-1:0]  data;
    } sbcp_beat_type;

    typedef enum logic [1:0] {SBCP_B_IDLE, SBCP_B_READ, SBCP_B_WRITE} sbcp_burst_type;
    typedef enum logic [1:0] {SBCP_C_IDLE, SBCP_C_LONG, SBCP_C_SHORT} sbcp_cal_type;

    // =========================================
    // Complete block state
    typedef struct packed {
        sbcp_pins_type                              p1;
        sbcp_pins_type                              p2;
        sbcp_beat_type                              w1;
        sbcp_beat_type                              w2;
        logic [`SBCP_CW-1:0]                        t1;
        logic [`SBCP_CW-1:0]                        t2;
        logic [`SBCP_CW-1:0]                        t3;
        logic [`SBCP_CW-1:0]                        tq;
        logic                                       cke_prev;
        logic [`SBCP_NB-1:0]                        bopen;
        logic [`SBCP_NB-1:0][`SBCP_RW-1:0]          brow;
        logic [`SBCP_NB-1:0][`SBCP_TW-1:0]          tpre;
        sbcp_burst_type                             bst;
        logic [2:0]                                 bbank;
        logic [2:0]                                 bstart;
        logic [2:0]                                 bbeat;
        logic [2:0]                                 blast;
        logic                                       bap;
        logic [`SBCP_NB*8-1:0][`SBCP_DW-1:0]        mem;
        sbcp_cal_type                               cst;
        logic [`SBCP_KW-1:0]                        ccnt;
        logic [`SBCP_CW-1:0]                        ron;
        logic [`SBCP_CW-1:0]                        odt;
        logic [`SBCP_RW-1:0]                        rrow;
        logic [`SBCP_TW-1:0]                        rcnt;
        logic [1:0]                                 fv;
        logic [1:0][`SBCP_DW-1:0]                   fd;
        logic                                       bact;
        logic                                       cbusy;
        logic                                       rbusy;
    } sbcp_state_type;

endpackage : sbcp_pkg

// ---- hw/sbcp_top.sv ----
//
// Contract
// [RL1] Controller waits init or operational window after each long calibration.
// [RL2] Long calibration runs engine, then applies driver and termination codes.
// [RL3] Short calibration corrects a small error within 64 cycles.
// [RL4] Activate opens the addressed row in the selected bank until precharged.
// [RL5] Controller precharges a bank before activating another row there.
// [RL6] Read start column comes from A[2:0], ordered by length and type.
// [RL7] Bit ten high auto-closes the row after the burst; low keeps it open.
// [RL8] With on-the-fly enabled, bit twelve low chops to four, high gives eight.
// [RL9] A read burst always runs to completion; nobody interrupts it.
// [RL10] Read is select low, row high, column low, write high, clock enable high.
// [RL11] Write is select low, row high, column low, write low, clock enable high.
// [RL12] Masked-low bytes are stored; masked-high bytes leave memory unchanged.
// [RL13] Precharge with bit ten closes all banks, else only the selected bank.
// [RL14] Controller may access other banks during auto precharge without conflict.
// [RL15] Precharge to idle or closing bank is a no-op but restarts its timer.
// [RL16] Refresh uses an internal row counter and ignores the address inputs.
// [RL17] Controller refreshes at least every average refresh interval on average.
// [RL18] After refresh only no-operation or deselect until refresh cycle time.
// [RL19] Controller postpones at most eight refreshes, gap at most nine intervals.
// [RL20] Postponed refreshes around self refresh total at most eight.
// [RL21] Controller issues at most 16 refreshes in two average intervals.
// [RL22] Clock enable high for precharge, activate, refresh; close banks first.
// [RL23] Commands decode from the control pins sampled on the rising edge.
// [RL24] Chip select high takes no command; running operations continue.
// [RL25] Activate, precharge, refresh, calibration use the standard encodings.
//
`include "sbcp_params.svh"

module sbcp_top (
    input  wire logic                     ref_clk_in,
    input  wire logic                     srst_in,
    input  sbcp_pkg::sbcp_pins_type       pins_in,
    input  sbcp_pkg::sbcp_beat_type       wbeat_in,
    input  wire logic [`SBCP_CW-1:0]      cal_target_in,
    input  wire logic                     init_done_in,
    input  wire logic                     otf_enable_in,
    input  wire logic                     fixed_chop_in,
    input  wire logic                     interleave_in,
    input  wire logic                     rready_in,
    output logic                          rvalid_out,
    output logic [`SBCP_DW-1:0]           rdata_out,
    output logic [`SBCP_NB-1:0]           bank_open_out,
    output logic                          burst_active_out,
    output logic                          cal_busy_out,
    output logic [`SBCP_CW-1:0]           ron_code_out,
    output logic [`SBCP_CW-1:0]           odt_code_out,
    output logic                          refresh_busy_out,
    output logic [`SBCP_RW-1:0]           refresh_row_out
);
    import sbcp_pkg::*;

    // =========================================
    // Helpers
    function automatic logic [2:0] burst_col(input logic [2:0] start,
                                             input logic [2:0] beat,
                                             input logic       ilv);
        logic [2:0] c;
        c = start ^ beat;
        if (!ilv) begin
            c = {start[2] ^ beat[2], 2'(start[1:0] + beat[1:0])};
        end
        return c;
    endfunction : burst_col

    function automatic logic [`SBCP_CW-1:0] step_to(input logic [`SBCP_CW-1:0] cur,
                                                    input logic [`SBCP_CW-1:0] tgt);
        logic [`SBCP_CW-1:0] v;
        v = cur;
        if (cur < tgt) begin
            v = cur + `SBCP_CW'h1;
        end else if (cur > tgt) begin
            v = cur - `SBCP_CW'h1;
        end
        return v;
    endfunction : step_to

    // =========================================
    // State
    sbcp_state_type st_r;
    sbcp_state_type st_nxt;

    logic                cmd_ok;
    logic                is_act;
    logic                is_rdwr;
    logic                is_pre;
    logic                is_ref;
    logic                is_zq;
    logic [1:0]          fv_pop;
    logic [2:0]          col;
    logic [5:0]          widx;
    logic                beat_go;
    logic [`SBCP_DW-1:0] wmerge;

    always_comb begin
        st_nxt  = st_r;
        cmd_ok  = 1'b0;
        is_act  = 1'b0;
        is_rdwr = 1'b0;
        is_pre  = 1'b0;
        is_ref  = 1'b0;
        is_zq   = 1'b0;
        col     = 3'h0;
        widx    = 6'h00;
        beat_go = 1'b0;
        wmerge  = '0;

        // =========================================
        // Pin synchronisers
        st_nxt.p1 = pins_in;
        st_nxt.p2 = st_r.p1;
        st_nxt.w1 = wbeat_in;
        st_nxt.w2 = st_r.w1;
        st_nxt.t1 = cal_target_in;
        st_nxt.t2 = st_r.t1;
        st_nxt.t3 = st_r.t2;
        if (st_r.t2 == st_r.t3) begin
            st_nxt.tq = st_r.t2;
        end
        st_nxt.cke_prev = st_r.p2.cke;

        // =========================================
        // Command decode
        cmd_ok  = st_r.cke_prev && st_r.p2.cke && !st_r.p2.cs_n; // RL23 RL24
        is_act  = cmd_ok && !st_r.p2.ras_n && st_r.p2.cas_n && st_r.p2.we_n; // RL25
        is_rdwr = cmd_ok && st_r.p2.ras_n && !st_r.p2.cas_n; // RL10 RL11
        is_pre  = cmd_ok && !st_r.p2.ras_n && st_r.p2.cas_n && !st_r.p2.we_n; // RL25
        is_ref  = cmd_ok && !st_r.p2.ras_n && !st_r.p2.cas_n && st_r.p2.we_n; // RL25
        is_zq   = cmd_ok && st_r.p2.ras_n && st_r.p2.cas_n && !st_r.p2.we_n; // RL25

        // =========================================
        // Precharge timers
        for (int b = 0; b < `SBCP_NB; b++) begin
            if (st_r.tpre[b] != '0) begin
                st_nxt.tpre[b] = st_r.tpre[b] - `SBCP_TW'h1;
            end
        end

        if (is_act) begin
            st_nxt.bopen[st_r.p2.ba] = 1'b1; // RL4
            st_nxt.brow[st_r.p2.ba]  = st_r.p2.addr[`SBCP_RW-1:0]; // RL4
        end

        if (is_pre) begin
            for (int b = 0; b < `SBCP_NB; b++) begin
                if (st_r.p2.addr[`SBCP_A_AP] || st_r.p2.ba == 3'(b)) begin // RL13
                    st_nxt.bopen[b] = 1'b0;
                    st_nxt.tpre[b]  = `SBCP_TW'(`SBCP_TRP_CYC); // RL15
                end
            end
        end

        // =========================================
        // Refresh
        if (st_r.rcnt != '0) begin
            st_nxt.rcnt = st_r.rcnt - `SBCP_TW'h1;
        end
        if (is_ref) begin
            st_nxt.rrow = st_r.rrow + `SBCP_RW'h1; // RL16
            st_nxt.rcnt = `SBCP_TW'(`SBCP_REFRESH_CYCLE_TIME_CYC);
        end

        // =========================================
        // Calibration engine
        if (is_zq && st_r.cst == SBCP_C_IDLE) begin
            if (st_r.p2.addr[`SBCP_A_AP]) begin
                st_nxt.cst  = SBCP_C_LONG; // RL2
                st_nxt.ccnt = init_done_in ? `SBCP_KW'(`SBCP_ZQOPER_CYC)
                                           : `SBCP_KW'(`SBCP_ZQINIT_CYC);
            end else begin
                st_nxt.cst  = SBCP_C_SHORT;
                st_nxt.ccnt = `SBCP_KW'(`SBCP_SHORT_IMPEDANCE_CALIBRATION_CYC); // RL3
            end
        end
        case (st_r.cst)
            SBCP_C_IDLE: begin
            end
            SBCP_C_LONG: begin
                st_nxt.ccnt = st_r.ccnt - `SBCP_KW'h1;
                if (st_r.ccnt == `SBCP_KW'h1) begin
                    st_nxt.ron = st_r.tq; // RL2
                    st_nxt.odt = st_r.tq; // RL2
                    st_nxt.cst = SBCP_C_IDLE;
                end
            end
            SBCP_C_SHORT: begin
                st_nxt.ccnt = st_r.ccnt - `SBCP_KW'h1;
                if (st_r.ccnt == `SBCP_KW'h1) begin
                    st_nxt.ron = step_to(st_r.ron, st_r.tq); // RL3
                    st_nxt.odt = step_to(st_r.odt, st_r.tq); // RL3
                    st_nxt.cst = SBCP_C_IDLE;
                end
            end
            default: begin
                st_nxt.cst = SBCP_C_IDLE;
            end
        endcase

        // =========================================
        // Read buffer drain
        fv_pop = st_r.fv;
        if (st_r.fv[0] && rready_in) begin
            st_nxt.fd[0] = st_r.fd[1];
            fv_pop       = {1'b0, st_r.fv[1]};
        end
        st_nxt.fv = fv_pop;

        // =========================================
        // Burst engine
        col  = burst_col(st_r.bstart, st_r.bbeat, interleave_in); // RL6
        widx = {st_r.bbank, col};
        case (st_r.bst)
            SBCP_B_IDLE: begin
                if (is_rdwr) begin
                    st_nxt.bst    = st_r.p2.we_n ? SBCP_B_READ : SBCP_B_WRITE; // RL10 RL11
                    st_nxt.bbank  = st_r.p2.ba;
                    st_nxt.bstart = st_r.p2.addr[2:0]; // RL6
                    st_nxt.bbeat  = 3'h0;
                    st_nxt.bap    = st_r.p2.addr[`SBCP_A_AP]; // RL7
                    st_nxt.blast  = `SBCP_LAST_BL8;
                    if (otf_enable_in ? !st_r.p2.addr[`SBCP_A_BL] : fixed_chop_in) begin // RL8
                        st_nxt.blast = `SBCP_LAST_BC4;
                    end
                end
            end
            SBCP_B_READ: begin
                if (!fv_pop[1]) begin
                    beat_go = 1'b1; // RL9
                    if (fv_pop[0]) begin
                        st_nxt.fd[1] = st_r.mem[widx];
                        st_nxt.fv    = 2'b11;
                    end else begin
                        st_nxt.fd[0] = st_r.mem[widx];
                        st_nxt.fv    = 2'b01;
                    end
                end
            end
            SBCP_B_WRITE: begin
                if (st_r.w2.valid) begin
                    beat_go = 1'b1;
                    wmerge  = st_r.mem[widx];
                    for (int m = 0; m < `SBCP_MW; m++) begin
                        if (!st_r.w2.mask[m]) begin
                            wmerge[m*8 +: 8] = st_r.w2.data[m*8 +: 8]; // RL12
                        end
                    end
                    st_nxt.mem[widx] = wmerge;
                end
            end
            default: begin
                st_nxt.bst = SBCP_B_IDLE;
            end
        endcase

        if (beat_go) begin
            st_nxt.bbeat = st_r.bbeat + 3'h1;
            if (st_r.bbeat == st_r.blast) begin
                st_nxt.bst = SBCP_B_IDLE;
                if (st_r.bap) begin
                    if (!(is_act && st_r.p2.ba == st_r.bbank)) begin
                        st_nxt.bopen[st_r.bbank] = 1'b0; // RL7
                    end
                    st_nxt.tpre[st_r.bbank]  = `SBCP_TW'(`SBCP_TRP_CYC);
                end
            end
        end

        // =========================================
        // Registered status flags
        st_nxt.bact  = st_nxt.bst != SBCP_B_IDLE;
        st_nxt.cbusy = st_nxt.cst != SBCP_C_IDLE;
        st_nxt.rbusy = st_nxt.rcnt != '0;

        if (srst_in) begin
            st_nxt       = '0;
            st_nxt.p1    = '1;
            st_nxt.p2    = '1;
            st_nxt.ron   = `SBCP_CODE_RST;
            st_nxt.odt   = `SBCP_CODE_RST;
            st_nxt.bst   = SBCP_B_IDLE;
            st_nxt.cst   = SBCP_C_IDLE;
            st_nxt.blast = `SBCP_LAST_BL8;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        st_r <= st_nxt;
    end

    // =========================================
    // Outputs
    assign rvalid_out       = st_r.fv[0];
    assign rdata_out        = st_r.fd[0];
    assign bank_open_out    = st_r.bopen;
    assign burst_active_out = st_r.bact;
    assign cal_busy_out     = st_r.cbusy;
    assign ron_code_out     = st_r.ron;
    assign odt_code_out     = st_r.odt;
    assign refresh_busy_out = st_r.rbusy;
    assign refresh_row_out  = st_r.rrow;

endmodule : sbcp_top

// ---- testbench/sbcp_ctrl_model.sv ----
`include "sbcp_params.svh"

// =====================
// Controller side of the command and data pins
module sbcp_ctrl_model (
    input wire logic                ref_clk_in,
    output sbcp_pkg::sbcp_pins_type pins_out,
    output sbcp_pkg::sbcp_beat_type beat_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import sbcp_pkg::*;

    initial begin
        pins_out = sbcp_pins_type'({5'h0F, 17'h00000});
        beat_out = '0;
    end

    task automatic cmd(input logic cs_n, input logic [2:0] code, input logic [2:0] ba,
                       input logic [`SBCP_AW-1:0] a, input int n,
                       input logic [7:0][`SBCP_DW-1:0] d, input logic [7:0][`SBCP_MW-1:0] m);
        int gap;
        gap = (code == 3'h1) ? `SBCP_REFRESH_CYCLE_TIME_CYC : 0;
        if (code == 3'h6) gap = a[`SBCP_A_AP] ? `SBCP_ZQINIT_CYC : `SBCP_SHORT_IMPEDANCE_CALIBRATION_CYC;
        @(posedge ref_clk_in);
        pins_out <= {cs_n, code, 1'b1, ba, a};
        @(posedge ref_clk_in);
        pins_out <= {5'h0F, ~ba, ~a};
        for (int i = 0; i < n; i++) begin
            beat_out <= {1'b1, m[i], d[i]};
            @(posedge ref_clk_in);
        end
        beat_out <= {1'b0, ~beat_out.mask, ~beat_out.data};
        repeat (gap) @(posedge ref_clk_in);
    endtask : cmd
endmodule : sbcp_ctrl_model

// ---- testbench/sbcp_top_bench.sv ----
`include "sbcp_params.svh"

// =====================
// Bench top
module sbcp_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import sbcp_pkg::*;

    logic                ref_clk_in;
    logic                srst_in;
    logic                init_done_in, otf_enable_in, fixed_chop_in, interleave_in, rready_in;
    logic                rvalid_out, cal_busy_out, refresh_busy_out, burst_active_out;
    logic [`SBCP_CW-1:0] cal_target_in, ron_code_out, odt_code_out;
    logic [`SBCP_DW-1:0] rdata_out;
    logic [`SBCP_NB-1:0] bank_open_out;
    logic [`SBCP_RW-1:0] refresh_row_out;
    sbcp_pins_type       pins_in;
    sbcp_beat_type       beat_in;
    logic [`SBCP_DW-1:0] mem [64];
    int                  error_cnt = 0;
    int                  num_checks = 0;

    sbcp_ctrl_model sbcp_ctrl_model_i (
        .ref_clk_in(ref_clk_in), .pins_out(pins_in), .beat_out(beat_in));
    sbcp_top sbcp_top_i (
        .ref_clk_in(ref_clk_in), .srst_in(srst_in), .pins_in(pins_in), .wbeat_in(beat_in),
        .cal_target_in(cal_target_in), .init_done_in(init_done_in),
        .otf_enable_in(otf_enable_in), .fixed_chop_in(fixed_chop_in),
        .interleave_in(interleave_in), .rready_in(rready_in), .rvalid_out(rvalid_out),
        .rdata_out(rdata_out), .bank_open_out(bank_open_out), .burst_active_out(burst_active_out),
        .cal_busy_out(cal_busy_out), .ron_code_out(ron_code_out), .odt_code_out(odt_code_out),
        .refresh_busy_out(refresh_busy_out), .refresh_row_out(refresh_row_out));

    function automatic logic [2:0] col_of(input logic [2:0] s, input logic [2:0] b);
        return interleave_in ? s ^ b : {s[2] ^ b[2], s[1:0] + b[1:0]};
    endfunction : col_of

    function automatic int nbeats(input logic a12);
        return (otf_enable_in ? a12 : !fixed_chop_in) ? 8 : 4;
    endfunction : nbeats

    function automatic logic [13:0] addr_of(input logic [2:0] s, input logic ap, input logic a12);
        return {1'b0, a12, 1'b0, ap, 7'h00, s};
    endfunction : addr_of

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic settle(input int n);
        repeat (n) @(negedge ref_clk_in);
    endtask : settle

    task automatic go(input logic [2:0] code, input logic [2:0] ba, input logic [13:0] a);
        sbcp_ctrl_model_i.cmd(1'b0, code, ba, a, 0, '0, '0);
        settle(4);
    endtask : go

    task automatic wr(input logic [2:0] b, input logic [2:0] s, input logic a12, input logic rnd);
        logic [7:0][15:0] d;
        logic [7:0][1:0]  m;
        for (int i = 0; i < 8; i++) begin
            d[i] = 16'($urandom);
            m[i] = rnd ? 2'($urandom) : 2'h0;
            for (int j = 0; j < 2; j++)
                if (i < nbeats(a12) && !m[i][j])
                    mem[{b, col_of(s, 3'(i))}][8*j +: 8] = d[i][8*j +: 8];
        end
        sbcp_ctrl_model_i.cmd(1'b0, 3'h4, b, addr_of(s, 1'b0, a12), nbeats(a12), d, m);
        settle(6);
    endtask : wr

    task automatic rd(input logic [2:0] b, input logic [2:0] s, input logic ap, input logic a12);
        int k;
        k = 0;
        sbcp_ctrl_model_i.cmd(1'b0, 3'h5, b, addr_of(s, ap, a12), 0, '0, '0);
        for (int t = 0; t < 60; t++) begin
            @(posedge ref_clk_in);
            rready_in <= 1'($urandom);
            @(negedge ref_clk_in);
            if (k == 0 && rvalid_out === 1'b1) begin
                check("burst active", 16'h0001, 16'(burst_active_out));
            end
            if (rvalid_out === 1'b1 && rready_in === 1'b1) begin
                check("read beat", mem[{b, col_of(s, 3'(k))}], rdata_out);
                k++;
            end
        end
        @(posedge ref_clk_in);
        rready_in <= 1'b1;
        check("beat count", 16'(nbeats(a12)), 16'(k));
        check("burst done", 16'h0000, 16'(burst_active_out));
        settle(4);
    endtask : rd

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    initial begin
        ref_clk_in = 1'b0;
        forever #2 ref_clk_in = ~ref_clk_in;
    end

    initial begin
        #100000;
        error_cnt++;
        give_verdict();
    end

    initial begin
        logic [5:0]  t;
        logic [2:0]  b;
        logic [13:0] r0;
        srst_in = 1'b1;
        {init_done_in, otf_enable_in, fixed_chop_in, interleave_in} = 4'h0;
        cal_target_in = 6'h00;
        rready_in = 1'b1;
        void'($urandom(32'hE74CA70C));
        repeat (16) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        settle(4);
        check("ron reset", 16'(`SBCP_CODE_RST), 16'(ron_code_out));
        check("odt reset", 16'(`SBCP_CODE_RST), 16'(odt_code_out));
        check("banks reset", 16'h0000, 16'(bank_open_out));
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            @(posedge ref_clk_in);
            t = (i < 2) ? 6'($urandom_range(40, 1)) : t + 6'h05;
            init_done_in <= (i != 0);
            cal_target_in <= t;
            settle(2);
            go(3'h6, 3'h0, (i < 2) ? 14'h0400 : 14'h0000);
            for (int w = 0; w < 600 && cal_busy_out !== 1'b0; w++) settle(1);
            check("drive code", 16'(i < 2 ? t : t - 6'h04), 16'(ron_code_out));
            check("term code", 16'(i < 2 ? t : t - 6'h04), 16'(odt_code_out));
        end
        $display("test calibration done");
        for (int i = 0; i < 8; i++) begin
            go(3'h3, 3'(i), 14'($urandom));
            wr(3'(i), 3'h0, 1'b0, 1'b0);
        end
        check("all open", 16'h00FF, 16'(bank_open_out));
        go(3'h2, 3'h0, 14'h0400);
        check("all closed", 16'h0000, 16'(bank_open_out));
        go(3'h2, 3'h2, 14'h0000);
        check("idle close", 16'h0000, 16'(bank_open_out));
        sbcp_ctrl_model_i.cmd(1'b1, 3'h3, 3'h5, 14'h0000, 0, '0, '0);
        settle(4);
        check("deselect", 16'h0000, 16'(bank_open_out));
        $display("test banks done");
        for (int it = 0; it < 8; it++) begin
            @(posedge ref_clk_in);
            {otf_enable_in, fixed_chop_in, interleave_in} <= 3'(it);
            b = 3'($urandom);
            settle(2);
            go(3'h3, b, 14'($urandom));
            wr(b, 3'($urandom), 1'($urandom), 1'b1);
            rd(b, 3'($urandom), 1'(it), 1'($urandom));
            check("row kept", 16'(!it[0]), 16'(bank_open_out[b]));
            go(3'h2, b, 14'h0000);
            check("bank closed", 16'h0000, 16'(bank_open_out[b]));
        end
        $display("test bursts done");
        for (int i = 0; i < 2; i++) begin
            r0 = refresh_row_out;
            go(3'h1, 3'($urandom), 14'($urandom));
            check("refresh row", 16'(r0 + 14'h0001), 16'(refresh_row_out));
        end
        $display("test refresh done");
        give_verdict();
    end
endmodule : sbcp_top_bench

// ---- testbench/sbcp_top_properties.sv ----
`include "sbcp_params.svh"

// =====================
// Port checker
module sbcp_top_properties (
    input wire logic                ref_clk_in,
    input wire logic                srst_in,
    input sbcp_pkg::sbcp_pins_type  pins_in,
    input wire logic [`SBCP_CW-1:0] cal_target_in,
    input wire logic                init_done_in,
    input wire logic                rready_in,
    input wire logic                rvalid_out,
    input wire logic [`SBCP_DW-1:0] rdata_out,
    input wire logic [`SBCP_NB-1:0] bank_open_out,
    input wire logic                cal_busy_out,
    input wire logic [`SBCP_CW-1:0] ron_code_out,
    input wire logic [`SBCP_CW-1:0] odt_code_out,
    input wire logic                refresh_busy_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import sbcp_pkg::*;
    logic [9:0] cal_cnt_r;
    logic [9:0] cal_exp_r;
    logic [9:0] ref_cnt_r;
    logic       cal_long_r;

    function automatic logic is_cmd(input sbcp_pins_type p, input logic [2:0] code);
        return !p.cs_n && p.cke && {p.ras_n, p.cas_n, p.we_n} == code;
    endfunction : is_cmd

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            cal_cnt_r  <= 10'h000;
            cal_exp_r  <= 10'h000;
            ref_cnt_r  <= 10'h000;
            cal_long_r <= 1'b0;
        end else begin
            cal_cnt_r <= cal_busy_out ? cal_cnt_r + 10'h001 : 10'h000;
            ref_cnt_r <= refresh_busy_out ? ref_cnt_r + 10'h001 : 10'h000;
            if (is_cmd(pins_in, 3'h6) && !cal_busy_out) begin
                cal_long_r <= pins_in.addr[`SBCP_A_AP];
                cal_exp_r  <= !pins_in.addr[`SBCP_A_AP] ? 10'h040 :
                              (init_done_in ? 10'h100 : 10'h200);
            end
        end
    end

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (srst_in);

    a_act_opens: assert property ((is_cmd(pins_in, 3'h3) && $past(pins_in.cke))
        |-> ##3 bank_open_out[$past(pins_in.ba, 3)]) else $error("bank not opened");
    a_pre_all: assert property ((is_cmd(pins_in, 3'h2) && pins_in.addr[10]
        && $past(pins_in.cke)) |-> ##3 bank_open_out == 8'h00) else $error("banks left open");
    a_ref_starts: assert property ((is_cmd(pins_in, 3'h1) && $past(pins_in.cke))
        |-> ##3 refresh_busy_out) else $error("refresh not started");
    a_ref_length: assert property ((!refresh_busy_out && ref_cnt_r != 10'h000)
        |-> ref_cnt_r == 10'h028) else $error("refresh busy length wrong");
    a_cal_window: assert property ((!cal_busy_out && cal_cnt_r != 10'h000)
        |-> cal_cnt_r == cal_exp_r) else $error("calibration window wrong");
    a_cal_apply: assert property (($fell(cal_busy_out) && cal_long_r) |-> ##[0:1]
        (ron_code_out == cal_target_in && odt_code_out == cal_target_in))
        else $error("calibrated codes not applied");
    a_code_quiet: assert property ($changed(ron_code_out) |-> (cal_busy_out
        || $past(cal_busy_out) || $past(cal_busy_out, 2))) else $error("code moved idle");
    a_read_hold: assert property ((rvalid_out && !rready_in) |=>
        (rvalid_out && $stable(rdata_out))) else $error("read beat dropped");
endmodule : sbcp_top_properties

bind sbcp_top sbcp_top_properties sbcp_top_properties_i (
    .ref_clk_in(ref_clk_in), .srst_in(srst_in), .pins_in(pins_in),
    .cal_target_in(cal_target_in), .init_done_in(init_done_in), .rready_in(rready_in),
    .rvalid_out(rvalid_out), .rdata_out(rdata_out), .bank_open_out(bank_open_out),
    .cal_busy_out(cal_busy_out), .ron_code_out(ron_code_out), .odt_code_out(odt_code_out),
    .refresh_busy_out(refresh_busy_out));
